// ==== common/sda_pkg.sv ====
// Package: constants for the slow-domain indirect access and reset block
package sda_pkg;
  // SFR addresses of the registers
  localparam logic [7:0] ADDR_DATA_HIGH = 8'hab;
  localparam logic [7:0] ADDR_DATA_LOW = 8'hac;
  localparam logic [7:0] ADDR_CONTROL = 8'had;
  localparam logic [7:0] ADDR_RESET_REASON = 8'hb1;
  // Control register fields
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_ADDR_MSB = 2;
  localparam int CTRL_ADDR_W = 3;
  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] REASON_RESET = 2'h2;
  localparam logic [15:0] WAKE_CFG_RESET = 16'h0000;
  // Reset reason fields
  localparam int REASON_OTHER_BIT = 0;
  localparam int REASON_ROM_BIT = 1;
  // Reset vectors
  localparam logic [15:0] VECTOR_CODE = 16'h0000;
  localparam logic [15:0] VECTOR_ROM = 16'h8000;
  // Indirect addresses of slow-domain targets
  localparam logic [2:0] IA_WDOG_LOAD = 3'h0;
  localparam logic [2:0] IA_WDOG_COUNT = 3'h1;
  localparam logic [2:0] IA_WAKE_LOWER = 3'h2;
  localparam logic [2:0] IA_WAKE_UPPER = 3'h3;
  // Wakeup field layout per pin nibble
  localparam int PIN_FIELD_W = 4;
  localparam int EDGE_LSB = 2;
  localparam int FILT_LSB = 0;
  // Filter codes and stable counts
  localparam logic [6:0] FILT_CNT_0 = 7'h00;
  localparam logic [6:0] FILT_CNT_1 = 7'h02;
  localparam logic [6:0] FILT_CNT_2 = 7'h08;
  localparam logic [6:0] FILT_CNT_3 = 7'h40;
  // Edge codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int SLOW_CLOCK_HZ = 4000;
  localparam int SLOW_DIV_CYCLES = CLK_HZ / SLOW_CLOCK_HZ;
  localparam int RESET_HOLD_CYCLES = 16;
  // Transfer engine states
  typedef enum logic [0:0] {SDA_IDLE, SDA_WAIT} sda_xfer_e;
endpackage

// ==== design/sda_pin_wake.sv ====
// Per-pin wakeup synchroniser, debounce filter and edge detector
`timescale 1ns/1ps
module sda_pin_wake (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow_tick,
  input wire logic pin,
  input wire logic [3:0] cfg,
  output logic wake
);
  // Two-stage synchroniser; first stage read only by second
  logic sync1_reg;
  logic sync2_reg;
  // Debounced level and stability counter
  logic filt_reg;
  logic [6:0] stab_reg;
  logic [6:0] need;
  logic [1:0] edge_sel;

  // Synchronise the asynchronous port pin
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Stable-pulse demand from the filter code
  always_comb begin
    edge_sel = cfg[sda_pkg::EDGE_LSB +: 2];
    case (cfg[sda_pkg::FILT_LSB +: 2])
      2'h0: need = sda_pkg::FILT_CNT_0;
      2'h1: need = sda_pkg::FILT_CNT_1;
      2'h2: need = sda_pkg::FILT_CNT_2;
      default: need = sda_pkg::FILT_CNT_3;
    endcase
  end

  // Debounce on slow-clock pulses: input must stay changed for need pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      filt_reg <= 1'b0;
      stab_reg <= 7'h00;
    end else if (sync2_reg == filt_reg) begin
      stab_reg <= 7'h00;
    end else if (need == sda_pkg::FILT_CNT_0) begin
      filt_reg <= sync2_reg; // Zero count passes straight through
    end else if (slow_tick) begin
      if (stab_reg + 7'h01 >= need) begin
        filt_reg <= sync2_reg;
        stab_reg <= 7'h00;
      end else begin
        stab_reg <= stab_reg + 7'h01;
      end
    end
  end

  // Edge selection on the filtered level change
  always_comb begin
    case (edge_sel)
      sda_pkg::EDGE_RISE: wake = (sync2_reg != filt_reg) && sync2_reg && (need == sda_pkg::FILT_CNT_0 ||
        (slow_tick && stab_reg + 7'h01 >= need));
      sda_pkg::EDGE_FALL: wake = (sync2_reg != filt_reg) && !sync2_reg && (need == sda_pkg::FILT_CNT_0 ||
        (slow_tick && stab_reg + 7'h01 >= need));
      sda_pkg::EDGE_BOTH: wake = (sync2_reg != filt_reg) && (need == sda_pkg::FILT_CNT_0 ||
        (slow_tick && stab_reg + 7'h01 >= need));
      default: wake = 1'b0;
    endcase
  end
endmodule

// ==== design/sda_top.sv ====
// Top: SFR indirect access to slow-clock watchdog and pin wakeup, reset control
`timescale 1ns/1ps
module sda_top #(
  parameter int SLOW_DIV = sda_pkg::SLOW_DIV_CYCLES,
  parameter int PINS = 8
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  output logic [7:0] SFR_RDATA,
  input wire logic [PINS-1:0] PORT0_PIN,
  output logic WAKEUP,
  output logic CPU_RESET,
  output logic BOOT_LOAD,
  output logic [15:0] RESET_VECTOR
);
  ////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] data_high_reg; // Transfer word, upper byte
  logic [7:0] data_low_reg; // Transfer word, lower byte
  logic ctrl_dir_reg; // Direction of last transfer
  logic [2:0] ctrl_addr_reg; // Indirect address
  logic busy_reg; // Transfer in flight
  logic [1:0] reason_reg; // Reset reason and vector select
  logic [15:0] wake_upper_reg; // Pins 7..4 wake config
  logic [15:0] wake_lower_reg; // Pins 3..0 wake config
  logic [15:0] wdog_load_reg; // Watchdog reload value
  logic [15:0] wdog_cnt_reg; // Watchdog down counter
  logic wdog_on_reg; // Watchdog armed
  logic wdog_fire; // Watchdog reached zero
  logic wdog_reload; // Write transfer to the watchdog load target completes
  logic sys_init; // Any reset source active
  logic [$clog2(SLOW_DIV)-1:0] div_reg; // Slow clock divider
  logic slow_tick_reg; // One pulse per slow-clock period
  logic [$clog2(sda_pkg::RESET_HOLD_CYCLES+1)-1:0] hold_reg; // Reset stretch
  sda_pkg::sda_xfer_e xfer_reg; // Transfer engine state
  logic [15:0] xfer_word; // Word handed to a target
  logic [PINS-1:0] pin_wake; // Per-pin wakeup events
  logic wr_ctrl;

  // Only two reset sources exist: the SRST power-on input and the watchdog
  assign sys_init = SRST || wdog_fire;
  assign wr_ctrl = SFR_WR && (SFR_ADDR == sda_pkg::ADDR_CONTROL);
  assign xfer_word = {data_high_reg, data_low_reg};

  ////////////////////////////////////////////////////////////////
  // Slow clock: the always-on logic steps on this enable, not a second clock
  always_ff @(posedge CLK) begin
    if (SRST || div_reg == $bits(div_reg)'(SLOW_DIV - 1)) begin
      div_reg <= '0;
      slow_tick_reg <= !SRST;
    end else begin
      div_reg <= div_reg + 1'b1;
      slow_tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Data bytes: CPU writes, and read results from the slow side land here
  always_ff @(posedge CLK) begin
    if (sys_init) begin
      data_high_reg <= sda_pkg::DATA_RESET;
      data_low_reg <= sda_pkg::DATA_RESET;
    end else if (xfer_reg == sda_pkg::SDA_WAIT && slow_tick_reg && !ctrl_dir_reg) begin
      // Read completes: the target value lands on the same edge that busy drops
      case (ctrl_addr_reg)
        sda_pkg::IA_WDOG_LOAD: {data_high_reg, data_low_reg} <= wdog_load_reg;
        sda_pkg::IA_WDOG_COUNT: {data_high_reg, data_low_reg} <= wdog_cnt_reg;
        sda_pkg::IA_WAKE_LOWER: {data_high_reg, data_low_reg} <= wake_lower_reg;
        sda_pkg::IA_WAKE_UPPER: {data_high_reg, data_low_reg} <= wake_upper_reg;
        default: {data_high_reg, data_low_reg} <= 16'h0000;
      endcase
    end else if (SFR_WR && SFR_ADDR == sda_pkg::ADDR_DATA_HIGH) begin
      data_high_reg <= SFR_WDATA; // Writes while busy are undefined by contract
    end else if (SFR_WR && SFR_ADDR == sda_pkg::ADDR_DATA_LOW) begin
      data_low_reg <= SFR_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control register and transfer engine
  always_ff @(posedge CLK) begin
    if (sys_init) begin
      ctrl_dir_reg <= 1'b0;
      ctrl_addr_reg <= 3'h0;
      busy_reg <= 1'b0;
      xfer_reg <= sda_pkg::SDA_IDLE;
    end else begin
      case (xfer_reg)
        sda_pkg::SDA_IDLE: begin
          if (wr_ctrl) begin
            ctrl_dir_reg <= SFR_WDATA[sda_pkg::CTRL_DIR_BIT];
            ctrl_addr_reg <= SFR_WDATA[sda_pkg::CTRL_ADDR_MSB -: sda_pkg::CTRL_ADDR_W];
            busy_reg <= 1'b1;
            xfer_reg <= sda_pkg::SDA_WAIT;
          end
        end
        default: begin
          // Finish on the next slow-clock pulse, mimicking the slow domain
          if (slow_tick_reg) begin
            busy_reg <= 1'b0;
            xfer_reg <= sda_pkg::SDA_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Slow-domain targets: written when a write transfer completes
  always_ff @(posedge CLK) begin
    if (sys_init) begin
      wake_upper_reg <= sda_pkg::WAKE_CFG_RESET;
      wake_lower_reg <= sda_pkg::WAKE_CFG_RESET;
      wdog_load_reg <= 16'h0000;
    end else if (xfer_reg == sda_pkg::SDA_WAIT && slow_tick_reg && ctrl_dir_reg) begin
      if (ctrl_addr_reg == sda_pkg::IA_WDOG_LOAD) begin
        wdog_load_reg <= xfer_word;
      end else if (ctrl_addr_reg == sda_pkg::IA_WAKE_LOWER) begin
        wake_lower_reg <= xfer_word;
      end else if (ctrl_addr_reg == sda_pkg::IA_WAKE_UPPER) begin
        wake_upper_reg <= xfer_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Watchdog: armed by any control write, stopped only by reset
  assign wdog_reload = xfer_reg == sda_pkg::SDA_WAIT && slow_tick_reg && ctrl_dir_reg &&
    ctrl_addr_reg == sda_pkg::IA_WDOG_LOAD;
  // A reload on the same tick wins over expiry: the first load arms with the counter still at zero
  assign wdog_fire = wdog_on_reg && slow_tick_reg && !wdog_reload &&
    (wdog_cnt_reg == 16'h0001 || wdog_cnt_reg == 16'h0000);
  always_ff @(posedge CLK) begin
    if (sys_init) begin
      wdog_on_reg <= 1'b0;
      wdog_cnt_reg <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        wdog_on_reg <= 1'b1;
      end
      if (wdog_reload) begin
        wdog_cnt_reg <= xfer_word; // Reload keeps the watchdog quiet
      end else if (wdog_on_reg && slow_tick_reg) begin
        wdog_cnt_reg <= wdog_cnt_reg - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reset reason and vector select
  always_ff @(posedge CLK) begin
    if (SRST) begin
      reason_reg <= sda_pkg::REASON_RESET; // Power-on leaves bit 0 clear
    end else if (wdog_fire) begin
      // Same init as power-on, but the reason shows another source
      reason_reg <= sda_pkg::REASON_RESET | 2'h1;
    end else if (SFR_WR && SFR_ADDR == sda_pkg::ADDR_RESET_REASON) begin
      reason_reg <= SFR_WDATA[1:0]; // Clearing bit 0 raises BOOT_LOAD
    end
  end

  ////////////////////////////////////////////////////////////////
  // Reset stretch and startup: hold the CPU, then release to the vector
  always_ff @(posedge CLK) begin
    if (sys_init) begin
      hold_reg <= $bits(hold_reg)'(sda_pkg::RESET_HOLD_CYCLES);
      CPU_RESET <= 1'b1;
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - 1'b1;
      CPU_RESET <= 1'b1;
    end else begin
      CPU_RESET <= 1'b0;
    end
  end

  // Vector and boot loader request follow the reason register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RESET_VECTOR <= sda_pkg::VECTOR_ROM;
      BOOT_LOAD <= 1'b1;
    end else begin
      RESET_VECTOR <= reason_reg[sda_pkg::REASON_ROM_BIT] ? sda_pkg::VECTOR_ROM : sda_pkg::VECTOR_CODE;
      BOOT_LOAD <= !reason_reg[sda_pkg::REASON_OTHER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // SFR read mux; busy is read-only and software writes to it are dropped
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SFR_RDATA <= 8'h00;
    end else if (!SFR_RD) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_ADDR == sda_pkg::ADDR_DATA_HIGH) begin
      SFR_RDATA <= data_high_reg;
    end else if (SFR_ADDR == sda_pkg::ADDR_DATA_LOW) begin
      SFR_RDATA <= data_low_reg;
    end else if (SFR_ADDR == sda_pkg::ADDR_CONTROL) begin
      SFR_RDATA <= {3'h0, busy_reg, ctrl_dir_reg, ctrl_addr_reg};
    end else if (SFR_ADDR == sda_pkg::ADDR_RESET_REASON) begin
      SFR_RDATA <= {6'h00, reason_reg};
    end else begin
      SFR_RDATA <= 8'h00; // Other SFRs belong to other blocks
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-pin wakeup: pin n uses nibble n mod 4 of its config word
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      sda_pin_wake u_wake (
        .clk(CLK),
        .srst(SRST),
        .slow_tick(slow_tick_reg),
        .pin(PORT0_PIN[gi]),
        .cfg(gi >= 4 ? wake_upper_reg[(gi%4)*sda_pkg::PIN_FIELD_W +: sda_pkg::PIN_FIELD_W]
                     : wake_lower_reg[(gi%4)*sda_pkg::PIN_FIELD_W +: sda_pkg::PIN_FIELD_W]),
        .wake(pin_wake[gi])
      );
    end
  endgenerate

  // Registered wakeup pulse from any pin
  always_ff @(posedge CLK) begin
    if (SRST) begin
      WAKEUP <= 1'b0;
    end else begin
      WAKEUP <= |pin_wake;
    end
  end
endmodule

// ==== testbench/sda_cpu_model.sv ====
// Partner model: CPU core side of the SFR bus
`timescale 1ns/1ps
module sda_cpu_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  logic [7:0] last; // Byte taken by the latest read
  // Idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    last = 8'h00;
  end
  ////////////////
  // Single write; data is scrambled after the strobe so stale bytes never pass
  task automatic wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // Single read; answer taken once the sampling edge has landed
  task automatic rdb(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    last = rdata;
  endtask
  // Write then read at once, so a short busy window is still seen
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    last = rdata;
  endtask
endmodule

// ==== testbench/sda_top_sva.sv ====
// Checker: port-level assertions for the indirect access and reset block
`timescale 1ns/1ps
module sda_top_chk #(
  parameter int SLOW_DIV = sda_pkg::SLOW_DIV_CYCLES,
  parameter int PINS = 8
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic [PINS-1:0] PORT0_PIN,
  input wire logic WAKEUP,
  input wire logic CPU_RESET,
  input wire logic BOOT_LOAD,
  input wire logic [15:0] RESET_VECTOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // Access steps and an eight-cycle reset hold
  sequence wr_at(a); SFR_WR && SFR_ADDR == a; endsequence
  sequence rd_at(a); SFR_RD && SFR_ADDR == a; endsequence
  sequence hold8; CPU_RESET [*8]; endsequence
  ////////////////
  chk_rdata_idle:
    assert property (!SFR_RD |=> SFR_RDATA == 8'h00) else $error("read data not zero outside a read");
  chk_ctrl_unused:
    assert property (rd_at(8'had) |=> SFR_RDATA[7:5] == 3'h0) else $error("control upper bits not zero");
  chk_word_high:
    assert property (wr_at(8'hab) ##2 rd_at(8'hab) |=> SFR_RDATA == $past(SFR_WDATA, 3))
      else $error("high data byte not kept");
  chk_busy_start:
    assert property (wr_at(8'had) ##1 rd_at(8'had) |=> SFR_RDATA[4] && SFR_RDATA[3:0] == $past(SFR_WDATA[3:0], 2))
      else $error("busy or fields wrong after control write");
  chk_reason_store:
    assert property (wr_at(8'hb1) ##2 rd_at(8'hb1) |=> SFR_RDATA == {6'h00, $past(SFR_WDATA[1:0], 3)})
      else $error("reason register not kept");
  chk_reason_outs:
    assert property (SFR_RD && SFR_ADDR == 8'hb1 && !SFR_WR |=>
      SFR_RDATA[0] != BOOT_LOAD && RESET_VECTOR == (SFR_RDATA[1] ? 16'h8000 : 16'h0000))
      else $error("boot or vector disagrees with reason");
  chk_por_values:
    assert property ($fell(SRST) |-> !WAKEUP && SFR_RDATA == 8'h00 && CPU_RESET && BOOT_LOAD &&
      RESET_VECTOR == 16'h8000) else $error("wrong outputs after power-on reset");
  chk_reset_hold:
    assert property ($fell(SRST) |-> hold8 ##1 hold8 ##1 CPU_RESET ##1 !CPU_RESET)
      else $error("cpu reset hold length wrong");
  chk_wdog_reason:
    assert property ($rose(CPU_RESET) && !$past(SRST) |-> ##[0:4] (!BOOT_LOAD && RESET_VECTOR == 16'h8000))
      else $error("watchdog reset did not skip the loader");
endmodule
bind sda_top sda_top_chk #(.SLOW_DIV(SLOW_DIV), .PINS(PINS)) u_chk (.CLK(CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR),
  .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .PORT0_PIN(PORT0_PIN),
  .WAKEUP(WAKEUP), .CPU_RESET(CPU_RESET), .BOOT_LOAD(BOOT_LOAD), .RESET_VECTOR(RESET_VECTOR));

// ==== testbench/test_slow_domain_indirect_access_reset.sv ====
// Testbench: SFR transfers, reset reason, pin wakeup and watchdog expiry
`timescale 1ns/1ps
module test_slow_domain_indirect_access_reset;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] PORT0_PIN = 8'h00;
  logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA;
  logic SFR_WR, SFR_RD, WAKEUP, CPU_RESET, BOOT_LOAD;
  logic rd_d = 1'b0; // A read answer is due at this edge
  logic [15:0] RESET_VECTOR;
  logic [15:0] seed = 16'hc9be; // Random source, starts at 51646
  logic [8:0] exp_q[$]; // Expected read bytes; bit 8 set means compare
  logic [8:0] note;
  logic [2:0] ias [4] = '{3'h2, 3'h3, 3'h5, 3'h7}; // Both configs, two unmapped
  int fail_count = 0;
  int total_checks = 0;
  int wake_n = 0;
  initial forever #25 CLK = ~CLK;
  // Short slow tick keeps the watchdog run brief
  sda_top #(.SLOW_DIV(8), .PINS(8)) DUT (.CLK(CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .PORT0_PIN(PORT0_PIN), .WAKEUP(WAKEUP),
    .CPU_RESET(CPU_RESET), .BOOT_LOAD(BOOT_LOAD), .RESET_VECTOR(RESET_VECTOR));
  sda_cpu_model cpu (.clk(CLK), .addr(SFR_ADDR), .wdata(SFR_WDATA), .wr(SFR_WR), .rd(SFR_RD), .rdata(SFR_RDATA));
  ////////////////
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Result watcher: oldest note against the byte returned after each read
  always @(posedge CLK) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      if (note[8]) cmp("sfr_rdata", {8'h00, note[7:0]}, {8'h00, SFR_RDATA});
    end
    rd_d <= SFR_RD;
    if (WAKEUP === 1'b1) wake_n++;
  end
  ////////////////
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic c);
    exp_q.push_back({c, e});
    cpu.rdb(a);
  endtask
  // Poll busy with a bound; a hang shows as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd_chk(sda_pkg::ADDR_CONTROL, 8'h00, 1'b0);
      n++;
    end while (cpu.last[sda_pkg::CTRL_BUSY_BIT] !== 1'b0 && n < 40);
    cmp("busy", 16'h0000, {15'h0, cpu.last[sda_pkg::CTRL_BUSY_BIT]});
  endtask
  task automatic ctrl(input logic dir, input logic [2:0] ia);
    exp_q.push_back({1'b1, 3'h0, 1'b1, dir, ia});
    cpu.wr_rd(sda_pkg::ADDR_CONTROL, {4'h0, dir, ia});
  endtask
  task automatic xfer_wr(input logic [2:0] ia, input logic [15:0] w);
    wait_idle();
    cpu.wrb(sda_pkg::ADDR_DATA_HIGH, w[15:8]);
    rd_chk(sda_pkg::ADDR_DATA_HIGH, w[15:8], 1'b1);
    cpu.wrb(sda_pkg::ADDR_DATA_LOW, w[7:0]);
    ctrl(1'b1, ia);
  endtask
  task automatic xfer_rd(input logic [2:0] ia, input logic [15:0] e);
    wait_idle();
    ctrl(1'b0, ia);
    wait_idle();
    rd_chk(sda_pkg::ADDR_DATA_HIGH, e[15:8], 1'b1);
    rd_chk(sda_pkg::ADDR_DATA_LOW, e[7:0], 1'b1);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (CPU_RESET !== lvl && n < lim) begin
      @(posedge CLK);
      n++;
    end
    cmp("cpu_reset", {15'h0, lvl}, {15'h0, CPU_RESET});
  endtask
  task automatic reason_out(input logic boot, input logic [15:0] vec);
    @(posedge CLK);
    #1;
    cmp("boot_load", {15'h0, boot}, {15'h0, BOOT_LOAD});
    cmp("reset_vector", vec, RESET_VECTOR);
  endtask
  // Toggle the pins in mask m once the new config has landed, and count wake pulses
  // over a window longer than the 64-tick filter
  task automatic pin_try(input logic [7:0] m, input logic lvl, input logic w);
    int s;
    wait_idle();
    s = wake_n;
    @(posedge CLK);
    PORT0_PIN <= lvl ? (PORT0_PIN | m) : (PORT0_PIN & ~m);
    repeat (600) @(posedge CLK);
    cmp("wake_count", {15'h0, w}, 16'(wake_n - s));
  endtask
  ////////////////
  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    wait_rst(1'b0, 100);
    rd_chk(sda_pkg::ADDR_DATA_HIGH, 8'h00, 1'b1);
    rd_chk(sda_pkg::ADDR_DATA_LOW, 8'h00, 1'b1);
    rd_chk(sda_pkg::ADDR_CONTROL, 8'h00, 1'b1);
    rd_chk(sda_pkg::ADDR_RESET_REASON, 8'h02, 1'b1);
    reason_out(1'b1, 16'h8000);
    cpu.wrb(sda_pkg::ADDR_RESET_REASON, 8'h00);
    rd_chk(sda_pkg::ADDR_RESET_REASON, 8'h00, 1'b1);
    reason_out(1'b1, 16'h0000);
    cpu.wrb(sda_pkg::ADDR_RESET_REASON, 8'h02);
    xfer_wr(sda_pkg::IA_WDOG_LOAD, 16'h0400);
    // Edge code e with filter code e on pin 0
    for (int e = 0; e < 4; e++) begin
      xfer_wr(sda_pkg::IA_WAKE_LOWER, 16'(e * 5));
      pin_try(8'h01, 1'b1, e[0]);
      pin_try(8'h01, 1'b0, e[1]);
    end
    // Random words through both configs and two unmapped targets
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xfer_wr(ias[i], seed);
      xfer_rd(ias[i], i < 2 ? seed : 16'h0000);
    end
    // Pin 7 sits in the top nibble of the upper config: rising edge, no filter
    xfer_wr(sda_pkg::IA_WAKE_UPPER, 16'h4000);
    pin_try(8'h80, 1'b1, 1'b1);
    pin_try(8'h80, 1'b0, 1'b0);
    // Watchdog expiry behaves as a reset that skips the loader
    wait_rst(1'b1, 12000);
    wait_rst(1'b0, 100);
    rd_chk(sda_pkg::ADDR_RESET_REASON, 8'h03, 1'b1);
    rd_chk(sda_pkg::ADDR_DATA_HIGH, 8'h00, 1'b1);
    reason_out(1'b0, 16'h8000);
    repeat (4) @(posedge CLK);
    give_verdict();
  end
  // Hang guard, well beyond the roughly 8300 cycles expected
  initial begin
    repeat (30000) @(posedge CLK);
    fail_count++;
    give_verdict();
  end
endmodule
